/* File: core/mdu_pkg.sv */
package mdu_pkg;

  // datapath widths
  localparam int WORD_W     = 16;
  localparam int LONG_W     = 32;
  localparam int MUL_IN_W   = 17;
  localparam int PROD_W     = 34;
  localparam int BYTE_W     = 8;
  localparam int LIT_W      = 5;
  localparam int ABS_ADDR_W = 13;
  localparam int CNT_W      = 5;
  localparam int IDX_W      = 4;
  localparam int PAIR_W     = 3;

  // repeat counts seen by the divider
  localparam logic [CNT_W-1:0] DIV_FIRST_COUNT = 5'h11;
  localparam logic [CNT_W-1:0] DIV_LAST_COUNT  = 5'h00;

  // destination pairs, index of the even register divided by two
  localparam logic [PAIR_W-1:0] PAIR_FORBIDDEN = 3'h7;
  localparam logic [PAIR_W-1:0] PAIR_FILE      = 3'h1;

  // fixed register numbers of divide results
  localparam logic [IDX_W-1:0] QUOT_IDX = 4'h0;
  localparam logic [IDX_W-1:0] REM_IDX  = 4'h1;

  typedef enum logic [2:0] {
    multiply_signed_signed,
    multiply_unsigned_unsigned,
    multiply_signed_by_unsigned,
    multiply_unsigned_by_signed,
    multiply_signed_literal,
    multiply_unsigned_literal,
    file_register_multiply_byte,
    file_register_multiply_word
  } mdu_mul_op_t;

  typedef enum logic [1:0] {
    divide_signed_long,
    divide_signed_word,
    divide_unsigned_long,
    divide_unsigned_word
  } mdu_div_op_t;

  // widen to the multiplier input, zero or sign fill
  function automatic logic [MUL_IN_W-1:0] ext17(input logic [WORD_W-1:0] v,
                                                 input logic sgn);
    return {sgn & v[WORD_W-1], v};
  endfunction

  // magnitude of a word, most negative value maps onto itself unsigned
  function automatic logic [WORD_W-1:0] mag16(input logic [WORD_W-1:0] v,
                                               input logic neg);
    return neg ? WORD_W'(-v) : v;
  endfunction

endpackage

/* File: core/mdu_dp_if.sv */
`timescale 1ns/10ps
// operand and result wires between the control and the arithmetic
interface mdu_dp_if;
  logic [mdu_pkg::MUL_IN_W-1:0] mul_a;
  logic [mdu_pkg::MUL_IN_W-1:0] mul_b;
  logic [mdu_pkg::PROD_W-1:0]   mul_p;
  logic [mdu_pkg::WORD_W-1:0]   div_rem;
  logic [mdu_pkg::WORD_W-1:0]   div_quo;
  logic [mdu_pkg::WORD_W-1:0]   div_mag;
  logic [mdu_pkg::WORD_W-1:0]   div_rem_nx;
  logic [mdu_pkg::WORD_W-1:0]   div_quo_nx;

  modport ctrl (output mul_a, mul_b, div_rem, div_quo, div_mag,
                input  mul_p, div_rem_nx, div_quo_nx);
  modport mul  (input  mul_a, mul_b, output mul_p);
  modport div  (input  div_rem, div_quo, div_mag,
                output div_rem_nx, div_quo_nx);
endinterface

/* File: core/mdu_mul17.sv */
`timescale 1ns/10ps
// single signed 17 x 17 multiplier shared by every multiply form
module mdu_mul17 (
  // operands and product
  mdu_dp_if.mul dp
);
  logic signed [mdu_pkg::MUL_IN_W-1:0] a_s;
  logic signed [mdu_pkg::MUL_IN_W-1:0] b_s;

  // extended operands always multiply as signed values
  assign a_s      = dp.mul_a;
  assign b_s      = dp.mul_b;
  assign dp.mul_p = a_s * b_s;
endmodule

/* File: core/mdu_div_step.sv */
`timescale 1ns/10ps
// one restoring shift-subtract step, one quotient bit per call
module mdu_div_step (
  // partial remainder, quotient and divisor magnitude
  mdu_dp_if.div dp
);
  logic [mdu_pkg::WORD_W:0] trial;

  // remainder stays below divisor, so 17 bits of trial never overflow
  always_comb begin
    trial = {dp.div_rem, dp.div_quo[mdu_pkg::WORD_W-1]};
    if (trial >= {1'b0, dp.div_mag}) begin
      dp.div_rem_nx = mdu_pkg::WORD_W'(trial - {1'b0, dp.div_mag});
      dp.div_quo_nx = {dp.div_quo[mdu_pkg::WORD_W-2:0], 1'b1};
    end else begin
      dp.div_rem_nx = trial[mdu_pkg::WORD_W-1:0];
      dp.div_quo_nx = {dp.div_quo[mdu_pkg::WORD_W-2:0], 1'b0};
    end
  end
endmodule

/* File: core/mdu_top.sv */
`timescale 1ns/10ps
// How it works
// - every product comes from one signed 17 by 17 multiplier
// - seventeenth bit is zero for unsigned, sign copy for signed operands
// - ss, uu, us, su word modes, word by 5-bit literal, byte by byte
// - 32-bit product goes to a chosen pair; the top pair is refused
// - pair is odd over even; high word odd, low word even
// - file multiply writes pair one; bytes touch only the even register
// - file multiply uses register two and a zero-extended 13-bit address
// - first operand from registers, second from data space or the 5-bit literal
// - product width is 32 bits with one or two sign bits if signed
// - all multiplies are integer, no fractional scaling
// - products written only as register-direct write enables
// - signed and unsigned long and word dividends by word divisor
// - quotient ends in register zero, remainder in register one
// - any register divisor, aligned pair as long dividend
// - eighteen steps for every form: one setup, sixteen steps of one quotient bit each, one sign fixup
// - repeat runs its target operand plus one times
// - state between steps lives in registers one, zero and n, c, z
// - steps may pause between iterations and resume from restored state
// - zero divisor traps after the first step completes
module mdu_top (
  // clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  // multiply request
  input  wire logic                          mul_req_in,
  input  wire mdu_pkg::mdu_mul_op_t          mul_op_in,
  input  wire logic [mdu_pkg::WORD_W-1:0]    mul_src_a_in,
  input  wire logic [mdu_pkg::WORD_W-1:0]    file_mul_low_in,
  input  wire logic [mdu_pkg::LIT_W-1:0]     mul_lit_in,
  input  wire logic [mdu_pkg::WORD_W-1:0]    mul_addr_in,
  input  wire logic [mdu_pkg::ABS_ADDR_W-1:0] file_addr_in,
  input  wire logic [mdu_pkg::PAIR_W-1:0]    mul_pair_in,
  // data space read
  output logic                               data_rd_out,
  output logic [mdu_pkg::WORD_W-1:0]         data_addr_out,
  input  wire logic [mdu_pkg::WORD_W-1:0]    data_in,
  // multiply write-back
  output logic [mdu_pkg::LONG_W-1:0]         prod_out,
  output logic                               wr_low_en_out,
  output logic                               wr_high_en_out,
  output logic [mdu_pkg::IDX_W-1:0]          wr_low_idx_out,
  output logic [mdu_pkg::IDX_W-1:0]          wr_high_idx_out,
  output logic                               mul_err_out,
  // divide step from the repeat sequencer
  input  wire logic                          div_step_in,
  input  wire mdu_pkg::mdu_div_op_t          div_op_in,
  input  wire logic [mdu_pkg::CNT_W-1:0]     loop_iteration_count_in,
  input  wire logic [mdu_pkg::WORD_W-1:0]    dividend_lo_in,
  input  wire logic [mdu_pkg::WORD_W-1:0]    dividend_hi_in,
  input  wire logic [mdu_pkg::WORD_W-1:0]    divisor_in,
  // context restore after an interrupt
  input  wire logic                          restore_in,
  input  wire logic [mdu_pkg::WORD_W-1:0]    restore_quot_in,
  input  wire logic [mdu_pkg::WORD_W-1:0]    restore_rem_in,
  input  wire logic                          restore_n_in,
  input  wire logic                          restore_c_in,
  input  wire logic                          restore_z_in,
  // divide results and flags
  output logic [mdu_pkg::WORD_W-1:0]         quotient_out,
  output logic [mdu_pkg::WORD_W-1:0]         remainder_out,
  output logic                               div_wr_out,
  output logic                               div_done_out,
  output logic                               div_trap_out,
  output logic                               flag_n_out,
  output logic                               flag_c_out,
  output logic                               flag_z_out
);
  mdu_dp_if dp ();

  mdu_mul17 u_mul (
    .dp (dp)
  );

  mdu_div_step u_step (
    .dp (dp)
  );

  // stage one: capture request and address data space
  mdu_pkg::mdu_mul_op_t            s1_op_reg, s1_op_next;
  logic                            s1_vld_reg, s1_vld_next;
  logic [mdu_pkg::WORD_W-1:0]      s1_a_reg, s1_a_next;
  logic [mdu_pkg::LIT_W-1:0]       s1_lit_reg, s1_lit_next;
  logic [mdu_pkg::PAIR_W-1:0]      s1_pair_reg, s1_pair_next;
  logic                            rd_reg, rd_next;
  logic [mdu_pkg::WORD_W-1:0]      addr_reg, addr_next;
  logic                            is_file;
  logic                            is_lit;

  always_comb begin
    is_file      = mul_op_in inside {mdu_pkg::file_register_multiply_byte,
                                     mdu_pkg::file_register_multiply_word};
    is_lit       = mul_op_in inside {mdu_pkg::multiply_signed_literal,
                                     mdu_pkg::multiply_unsigned_literal};
    s1_vld_next  = mul_req_in;
    s1_op_next   = mul_op_in;
    s1_lit_next  = mul_lit_in;
    s1_a_next    = is_file ? file_mul_low_in : mul_src_a_in;
    s1_pair_next = is_file ? mdu_pkg::PAIR_FILE : mul_pair_in;
    rd_next      = mul_req_in & ~is_lit;
    addr_next    = addr_reg;
    if (mul_req_in) begin
      addr_next = is_file ? {{(mdu_pkg::WORD_W-mdu_pkg::ABS_ADDR_W){1'b0}},
                             file_addr_in} : mul_addr_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_vld_reg  <= 1'b0;
      s1_op_reg   <= mdu_pkg::multiply_unsigned_unsigned;
      s1_a_reg    <= '0;
      s1_lit_reg  <= '0;
      s1_pair_reg <= '0;
      rd_reg      <= 1'b0;
      addr_reg    <= '0;
    end else begin
      s1_vld_reg  <= s1_vld_next;
      s1_op_reg   <= s1_op_next;
      s1_a_reg    <= s1_a_next;
      s1_lit_reg  <= s1_lit_next;
      s1_pair_reg <= s1_pair_next;
      rd_reg      <= rd_next;
      addr_reg    <= addr_next;
    end
  end

  // stage two: extend operands, multiply, register write-back
  logic                            a_sgn, b_sgn, byte_op;
  logic [mdu_pkg::WORD_W-1:0]      opa, opb;
  logic [mdu_pkg::LONG_W-1:0]      prod_reg, prod_next;
  logic                            wl_reg, wl_next, wh_reg, wh_next;
  logic [mdu_pkg::PAIR_W-1:0]      pair_reg, pair_next;
  logic                            err_reg, err_next;

  always_comb begin
    a_sgn   = 1'b0;
    b_sgn   = 1'b0;
    byte_op = 1'b0;
    opa     = s1_a_reg;
    opb     = data_in;
    unique case (s1_op_reg)
      mdu_pkg::multiply_signed_signed: begin
        a_sgn = 1'b1;
        b_sgn = 1'b1;
      end
      mdu_pkg::multiply_signed_by_unsigned: a_sgn = 1'b1;
      mdu_pkg::multiply_unsigned_by_signed: b_sgn = 1'b1;
      mdu_pkg::multiply_signed_literal: begin
        a_sgn = 1'b1;
        opb   = {{(mdu_pkg::WORD_W-mdu_pkg::LIT_W){1'b0}}, s1_lit_reg};
      end
      mdu_pkg::multiply_unsigned_literal:
        opb = {{(mdu_pkg::WORD_W-mdu_pkg::LIT_W){1'b0}}, s1_lit_reg};
      mdu_pkg::file_register_multiply_byte: begin
        byte_op = 1'b1;
        opa = {{mdu_pkg::BYTE_W{1'b0}}, s1_a_reg[mdu_pkg::BYTE_W-1:0]};
        opb = {{mdu_pkg::BYTE_W{1'b0}}, data_in[mdu_pkg::BYTE_W-1:0]};
      end
      mdu_pkg::multiply_unsigned_unsigned,
      mdu_pkg::file_register_multiply_word: ;
    endcase
    dp.mul_a  = mdu_pkg::ext17(opa, a_sgn);
    dp.mul_b  = mdu_pkg::ext17(opb, b_sgn);
    // integer product: low 32 bits, no fractional shift
    prod_next = dp.mul_p[mdu_pkg::LONG_W-1:0];
    pair_next = s1_pair_reg;
    err_next  = s1_vld_reg & (s1_pair_reg == mdu_pkg::PAIR_FORBIDDEN);
    wl_next   = s1_vld_reg & ~err_next;
    wh_next   = s1_vld_reg & ~err_next & ~byte_op;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prod_reg <= '0;
      wl_reg   <= 1'b0;
      wh_reg   <= 1'b0;
      pair_reg <= '0;
      err_reg  <= 1'b0;
    end else begin
      prod_reg <= prod_next;
      wl_reg   <= wl_next;
      wh_reg   <= wh_next;
      pair_reg <= pair_next;
      err_reg  <= err_next;
    end
  end

  // divide: state kept in quotient and remainder registers plus flags
  logic [mdu_pkg::WORD_W-1:0]      quotient_reg, quotient_next;
  logic [mdu_pkg::WORD_W-1:0]      remainder_reg, remainder_next;
  logic                            n_reg, n_next, c_reg, c_next;
  logic                            z_reg, z_next;
  logic                            dwr_reg, dwr_next, done_reg, done_next;
  logic                            trap_reg, trap_next;
  logic                            d_sgn, d_long;
  logic [mdu_pkg::LONG_W-1:0]      dvd, dvd_mag;

  always_comb begin
    d_sgn  = div_op_in inside {mdu_pkg::divide_signed_long,
                               mdu_pkg::divide_signed_word};
    d_long = div_op_in inside {mdu_pkg::divide_signed_long,
                               mdu_pkg::divide_unsigned_long};
    // word dividends sign-extend if signed, zero-extend if unsigned, so one path serves both sizes
    dvd = d_long ? {dividend_hi_in, dividend_lo_in}
                 : {{mdu_pkg::WORD_W{d_sgn & dividend_lo_in[mdu_pkg::WORD_W-1]}},
                    dividend_lo_in};
    dvd_mag = (d_sgn & dvd[mdu_pkg::LONG_W-1]) ? mdu_pkg::LONG_W'(-dvd) : dvd;
    dp.div_rem = remainder_reg;
    dp.div_quo = quotient_reg;
    dp.div_mag = mdu_pkg::mag16(divisor_in,
                                d_sgn & divisor_in[mdu_pkg::WORD_W-1]);
    quotient_next  = quotient_reg;
    remainder_next = remainder_reg;
    n_next    = n_reg;
    c_next    = c_reg;
    z_next    = z_reg;
    dwr_next  = 1'b0;
    done_next = 1'b0;
    trap_next = 1'b0;
    if (restore_in) begin
      // resume after an interrupt from the saved context
      quotient_next  = restore_quot_in;
      remainder_next = restore_rem_in;
      n_next = restore_n_in;
      c_next = restore_c_in;
      z_next = restore_z_in;
    end else if (div_step_in) begin
      // the phase comes from the repeat count, not a private counter
      if (loop_iteration_count_in == mdu_pkg::DIV_FIRST_COUNT) begin
        if (divisor_in == '0) begin
          trap_next = 1'b1;
          c_next    = 1'b0;
        end else begin
          n_next = d_sgn & dvd[mdu_pkg::LONG_W-1];
          z_next = d_sgn & divisor_in[mdu_pkg::WORD_W-1];
          c_next = 1'b1; // divisor accepted, steps may run
          remainder_next = dvd_mag[mdu_pkg::LONG_W-1:mdu_pkg::WORD_W];
          quotient_next  = dvd_mag[mdu_pkg::WORD_W-1:0];
          dwr_next = 1'b1;
        end
      end else if (loop_iteration_count_in == mdu_pkg::DIV_LAST_COUNT) begin
        if (c_reg) begin
          quotient_next  = mdu_pkg::mag16(quotient_reg, n_reg ^ z_reg);
          remainder_next = mdu_pkg::mag16(remainder_reg, n_reg);
          dwr_next  = 1'b1;
          done_next = 1'b1;
        end
      end else if (c_reg) begin
        quotient_next  = dp.div_quo_nx;
        remainder_next = dp.div_rem_nx;
        dwr_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      quotient_reg  <= '0;
      remainder_reg <= '0;
      n_reg    <= 1'b0;
      c_reg    <= 1'b0;
      z_reg    <= 1'b0;
      dwr_reg  <= 1'b0;
      done_reg <= 1'b0;
      trap_reg <= 1'b0;
    end else begin
      quotient_reg  <= quotient_next;
      remainder_reg <= remainder_next;
      n_reg    <= n_next;
      c_reg    <= c_next;
      z_reg    <= z_next;
      dwr_reg  <= dwr_next;
      done_reg <= done_next;
      trap_reg <= trap_next;
    end
  end

  // outputs straight from flip-flops
  assign data_rd_out     = rd_reg;
  assign data_addr_out   = addr_reg;
  assign prod_out        = prod_reg;
  assign wr_low_en_out   = wl_reg;
  assign wr_high_en_out  = wh_reg;
  assign wr_low_idx_out  = {pair_reg, 1'b0};
  assign wr_high_idx_out = {pair_reg, 1'b1};
  assign mul_err_out     = err_reg;
  assign quotient_out    = quotient_reg;
  assign remainder_out   = remainder_reg;
  assign div_wr_out      = dwr_reg;
  assign div_done_out    = done_reg;
  assign div_trap_out    = trap_reg;
  assign flag_n_out      = n_reg;
  assign flag_c_out      = c_reg;
  assign flag_z_out      = z_reg;

  // checks
  property p_forbidden_pair;
    @(posedge clk_in) disable iff (rst_in)
    mul_req_in && !is_file && mul_pair_in == mdu_pkg::PAIR_FORBIDDEN
    |-> ##2 mul_err_out && !wr_low_en_out && !wr_high_en_out;
  endproperty
  a_forbidden_pair: assert property (p_forbidden_pair)
    else $error("product written to forbidden pair");

  property p_pair_aligned;
    @(posedge clk_in) disable iff (rst_in)
    wr_low_en_out |-> !wr_low_idx_out[0] &&
      wr_high_idx_out == (wr_low_idx_out | 4'h1);
  endproperty
  a_pair_aligned: assert property (p_pair_aligned)
    else $error("destination pair not odd over even");

  property p_file_byte;
    @(posedge clk_in) disable iff (rst_in)
    mul_req_in && mul_op_in == mdu_pkg::file_register_multiply_byte
    |-> ##2 wr_low_en_out && !wr_high_en_out &&
      wr_low_idx_out == 4'h2 && prod_out[31:16] == 16'h0000;
  endproperty
  a_file_byte: assert property (p_file_byte)
    else $error("byte file multiply wrote wrong registers");

  property p_file_addr;
    @(posedge clk_in) disable iff (rst_in)
    mul_req_in && is_file
    |=> data_rd_out && data_addr_out[15:13] == 3'h0 &&
      data_addr_out[12:0] == $past(file_addr_in);
  endproperty
  a_file_addr: assert property (p_file_addr)
    else $error("file multiply address not zero extended");

  property p_ss_product;
    @(posedge clk_in) disable iff (rst_in)
    mul_req_in && mul_op_in == mdu_pkg::multiply_signed_signed
    ##1 1'b1 |=> prod_out == 32'($signed($past(s1_a_reg, 1)) *
                                 $signed($past(data_in, 1)));
  endproperty
  a_ss_product: assert property (p_ss_product)
    else $error("signed product wrong");

  property p_uu_product;
    @(posedge clk_in) disable iff (rst_in)
    mul_req_in && mul_op_in == mdu_pkg::multiply_unsigned_unsigned
    ##1 1'b1 |=> prod_out == 32'($past(s1_a_reg, 1)) *
                             32'($past(data_in, 1));
  endproperty
  a_uu_product: assert property (p_uu_product)
    else $error("unsigned product wrong");

  property p_zero_trap;
    @(posedge clk_in) disable iff (rst_in)
    div_step_in && !restore_in && divisor_in == 16'h0000 &&
    loop_iteration_count_in == mdu_pkg::DIV_FIRST_COUNT
    |=> div_trap_out && !flag_c_out && !div_wr_out;
  endproperty
  a_zero_trap: assert property (p_zero_trap)
    else $error("zero divisor did not trap");

  property p_done_count;
    @(posedge clk_in) disable iff (rst_in)
    div_done_out |-> $past(loop_iteration_count_in) == 5'h00 &&
      $past(div_step_in) && div_wr_out;
  endproperty
  a_done_count: assert property (p_done_count)
    else $error("divide finished off the last count");

  property p_rem_sign;
    @(posedge clk_in) disable iff (rst_in)
    div_done_out && remainder_out != 16'h0000 && flag_z_out == 1'b0
    |-> remainder_out[15] == flag_n_out || remainder_out == 16'h8000;
  endproperty
  a_rem_sign: assert property (p_rem_sign)
    else $error("remainder sign differs from dividend");

endmodule

/* File: test/mdu_seq_model.sv */
`timescale 1ns/10ps
// far side stand-in: repeat sequencer for divides, data-space read port
module mdu_seq_model (
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  // bench control
  input  wire logic                       go_in,
  input  wire logic                       hold_in,
  input  wire logic [mdu_pkg::WORD_W-1:0] rd_val_in,
  // design side
  input  wire logic                       rd_in,
  output logic                            step_out,
  output logic [mdu_pkg::CNT_W-1:0]       count_out,
  output logic [mdu_pkg::WORD_W-1:0]      data_out
);
  logic                      busy_reg;
  logic                      busy_next;
  logic [mdu_pkg::CNT_W-1:0] count_reg;
  logic [mdu_pkg::CNT_W-1:0] count_next;

  // repeat of seventeen, counted down to zero
  always_comb begin
    busy_next  = busy_reg;
    count_next = count_reg;
    if (go_in) begin
      busy_next  = 1'b1;
      count_next = mdu_pkg::DIV_FIRST_COUNT;
    end else if (step_out) begin
      busy_next  = (count_reg != mdu_pkg::DIV_LAST_COUNT);
      count_next = count_reg - 5'h01;
    end
  end

  // state registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_reg  <= 1'b0;
      count_reg <= 5'h00;
    end else begin
      busy_reg  <= busy_next;
      count_reg <= count_next;
    end
  end

  // a paused repeat (pending interrupt) issues no step
  assign step_out  = busy_reg & ~hold_in;
  assign count_out = count_reg;
  // second operand from data space; stale value never shown unstrobed
  assign data_out  = rd_in ? rd_val_in : ~rd_val_in;
endmodule

/* File: test/cpu_multiply_divide_unit_tb.sv */
`timescale 1ns/10ps
module cpu_multiply_divide_unit_tb;
  logic                  clk_in, rst_in, mul_req_in, data_rd_out, go, hold;
  logic                  wr_low_en_out, wr_high_en_out, mul_err_out;
  logic                  div_step_in, restore_in, div_wr_out, div_done_out;
  logic                  div_trap_out, flag_n_out, flag_c_out, flag_z_out;
  logic                  restore_n_in, restore_c_in, restore_z_in;
  logic [15:0]           mul_src_a_in, file_mul_low_in, mul_addr_in;
  logic [15:0]           data_addr_out, data_in, dividend_lo_in, rd_val;
  logic [15:0]           dividend_hi_in, divisor_in, quotient_out;
  logic [15:0]           remainder_out, restore_quot_in, restore_rem_in;
  logic [31:0]           prod_out;
  logic [12:0]           file_addr_in;
  logic [4:0]            mul_lit_in, loop_iteration_count_in;
  logic [3:0]            wr_low_idx_out, wr_high_idx_out;
  logic [2:0]            mul_pair_in;
  mdu_pkg::mdu_mul_op_t  mul_op_in;
  mdu_pkg::mdu_div_op_t  div_op_in;
  int                    num_errors = 0;
  int                    n_compared = 0;

  mdu_top dut_u (.*);
  mdu_seq_model seq_u (.clk_in(clk_in), .rst_in(rst_in), .go_in(go),
    .hold_in(hold), .rd_val_in(rd_val), .rd_in(data_rd_out),
    .step_out(div_step_in), .count_out(loop_iteration_count_in),
    .data_out(data_in));

  // free-running core clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one multiply; the expected product comes from a 34-bit signed model
  task automatic mul_run(input mdu_pkg::mdu_mul_op_t op,
                         input logic [15:0] a, input logic [15:0] b,
                         input logic [2:0] pair);
    logic        fil, lit, byt, err, sa, sb;
    logic [15:0] x, y;
    logic [2:0]  pe;
    logic [33:0] p;
    fil = op inside {mdu_pkg::file_register_multiply_byte,
                     mdu_pkg::file_register_multiply_word};
    lit = op inside {mdu_pkg::multiply_signed_literal,
                     mdu_pkg::multiply_unsigned_literal};
    byt = (op == mdu_pkg::file_register_multiply_byte);
    sa  = op inside {mdu_pkg::multiply_signed_signed,
                     mdu_pkg::multiply_signed_by_unsigned,
                     mdu_pkg::multiply_signed_literal};
    sb  = op inside {mdu_pkg::multiply_signed_signed,
                     mdu_pkg::multiply_unsigned_by_signed};
    x   = byt ? {8'h00, a[7:0]} : a;
    y   = lit ? {11'h000, b[4:0]} : (byt ? {8'h00, b[7:0]} : b);
    err = !fil && pair == 3'h7;
    pe  = fil ? 3'h1 : pair;
    p   = $signed({sa & x[15], x}) * $signed({sb & y[15], y});
    @(posedge clk_in);
    mul_req_in      <= 1'b1;
    mul_op_in       <= op;
    mul_src_a_in    <= a;
    file_mul_low_in <= a;
    mul_lit_in      <= b[4:0];
    mul_pair_in     <= pair;
    rd_val          <= b;
    @(posedge clk_in);
    mul_req_in <= 1'b0;
    #1;
    check(data_rd_out, !lit);
    if (!lit) check(data_addr_out, fil ? 16'h1abc : 16'h4c2e);
    @(posedge clk_in);
    #1;
    check({mul_err_out, wr_low_en_out, wr_high_en_out},
          {err, !err, !err && !byt});
    if (!err) check({prod_out, wr_low_idx_out, wr_high_idx_out},
      {byt ? {16'h0000, p[15:0]} : p[31:0], pe, 1'b0, pe, 1'b1});
  endtask

  // one divide under the sequencer; brk below 30 pauses it and restores
  task automatic div_run(input mdu_pkg::mdu_div_op_t op,
                         input logic [15:0] hi, input logic [15:0] lo,
                         input logic [15:0] dvs, input int brk);
    logic        sg, lg;
    longint      dd, ds, q, r;
    int          dn, tn;
    logic [15:0] sq, sr;
    logic [2:0]  sf;
    sg = op inside {mdu_pkg::divide_signed_long, mdu_pkg::divide_signed_word};
    lg = op inside {mdu_pkg::divide_signed_long,
                    mdu_pkg::divide_unsigned_long};
    dd = lg ? (sg ? longint'($signed({hi, lo})) : longint'({hi, lo}))
            : (sg ? longint'($signed(lo)) : longint'(lo));
    ds = sg ? longint'($signed(dvs)) : longint'(dvs);
    q  = (ds != 0) ? dd / ds : 0;
    r  = (ds != 0) ? dd % ds : 0;
    dn = 0;
    tn = 0;
    @(posedge clk_in);
    div_op_in      <= op;
    dividend_hi_in <= hi;
    dividend_lo_in <= lo;
    divisor_in     <= dvs;
    go             <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    for (int n = 1; n <= 26; n++) begin
      @(posedge clk_in);
      if (n == brk) hold <= 1'b1;
      if (n == brk + 1) begin
        restore_in      <= 1'b1;
        restore_quot_in <= 16'h5a5a;
        restore_rem_in  <= 16'ha5a5;
        {restore_n_in, restore_c_in, restore_z_in} <= 3'h5;
      end
      if (n == brk + 2) begin
        restore_quot_in <= sq;
        restore_rem_in  <= sr;
        {restore_n_in, restore_c_in, restore_z_in} <= sf;
      end
      if (n == brk + 3) begin
        restore_in <= 1'b0;
        hold       <= 1'b0;
      end
      #1;
      if (n == brk) begin
        sq = quotient_out;
        sr = remainder_out;
        sf = {flag_n_out, flag_c_out, flag_z_out};
      end
      if (div_done_out === 1'b1 && dn == 0) begin
        dn = n;
        check({quotient_out, remainder_out},
              {q[15:0], r[15:0]});
      end
      if (div_trap_out === 1'b1 && tn == 0) tn = n;
      if (n == 1) check({div_wr_out, flag_c_out}, {ds != 0, ds != 0});
      if (n == 1 && ds != 0) check({flag_n_out, flag_z_out},
                                   {dd < 0, ds < 0});
    end
    check(dn, ds == 0 ? 0 : (brk < 30 ? 21 : 18));
    check(tn, ds == 0 ? 1 : 0);
    if (ds != 0 && dn == 0) stop_test();
  endtask

  // main sequence
  initial begin
    {rst_in, go, hold, restore_in, mul_req_in} = 5'h10;
    {restore_n_in, restore_c_in, restore_z_in} = 3'h0;
    {mul_src_a_in, file_mul_low_in, rd_val} = 48'h0;
    {dividend_lo_in, dividend_hi_in, divisor_in} = 48'h0;
    {restore_quot_in, restore_rem_in, mul_lit_in, mul_pair_in} = 40'h0;
    mul_addr_in  = 16'h4c2e;
    file_addr_in = 13'h1abc;
    mul_op_in    = mdu_pkg::multiply_signed_signed;
    div_op_in    = mdu_pkg::divide_signed_long;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      mul_run(mdu_pkg::mdu_mul_op_t'(i), 16'h8003, 16'hfffb,
              3'h2);
    end
    mul_run(mdu_pkg::multiply_signed_signed, 16'h7fff, 16'h8000,
            3'h7);
    mul_run(mdu_pkg::multiply_unsigned_unsigned, 16'hffff, 16'hffff,
            3'h6);
    mul_run(mdu_pkg::file_register_multiply_word, 16'hffff, 16'h0002,
            3'h7);
    div_run(mdu_pkg::divide_signed_long, 16'hfffe, 16'h7960, 16'h0007,
            99);
    div_run(mdu_pkg::divide_unsigned_long, 16'h0001, 16'h0000, 16'h0003,
            99);
    div_run(mdu_pkg::divide_signed_word, 16'ha5a5, 16'h8001, 16'hfffd,
            99);
    div_run(mdu_pkg::divide_unsigned_word, 16'ha5a5, 16'hffff, 16'h00ff,
            99);
    div_run(mdu_pkg::divide_signed_long, 16'hfffe, 16'h7960, 16'hfff9,
            8);
    div_run(mdu_pkg::divide_unsigned_word, 16'h0000, 16'h1234, 16'h0000,
            99);
    stop_test();
  end
endmodule
